// ===== shared/rtu_query_pkg.sv
// Constants and types for the serial remote-terminal query handler.
// Assumes one 10 MHz core clock and a byte-wide receiver and transmitter outside.
// How it works
// - Station address zero is broadcast: act on it, never reply.
// - Program write: code 72, start and count high byte first, byte count, data, check.
// - Program write word count must be 1 to 125.
// - Accept only if start plus count is below highest program address plus two.
// - Byte count must be 2 to 250 and match the data bytes.
// - Data words ascend from start address, high byte before low byte.
// - Normal reply echoes address, code, start, count, then a fresh check field.
// - No program write while the memory protect switch is set.
// - Stop the attached processor before writing its program memory.
// - Exception reply: address, code plus 128, subcode 1 to 4, check; never broadcast.
// - Subcode 1 for function codes outside 1-8, 15, 16, 17, 65-72.
// - Subcode 2 for point or register ranges the processor lacks.
// - Subcode 2 for diagnostic codes other than 0, 1, 4.
// - Subcode 2 for scratch writes outside 0, 1, 5CH-7FH, or unavailable scratch reads.
// - Subcode 2 when program read or write reaches past program memory.
// - Subcode 3 unless data is 0 or FFH followed by 0 for force or restart.
// - Subcode 4 when the exchange with the attached processor fails.
// - Three character times of silence mid-frame end it without reply.
// - A query waits unprocessed while the other serial port is busy.
// - Bad check, short data, framing, overrun or parity errors drop the frame silently.
package rtu_query_pkg;
  localparam logic [7:0] BCAST_ADDR = 8'h00;
  localparam logic [7:0] FN_RD_OUT = 8'h01;
  localparam logic [7:0] FN_RD_IN = 8'h02;
  localparam logic [7:0] FN_RD_HOLD = 8'h03;
  localparam logic [7:0] FN_RD_INREG = 8'h04;
  localparam logic [7:0] FN_FORCE = 8'h05;
  localparam logic [7:0] FN_PRESET = 8'h06;
  localparam logic [7:0] FN_STATUS = 8'h07;
  localparam logic [7:0] FN_DIAG = 8'h08;
  localparam logic [7:0] FN_MULTI_PT = 8'h0F;
  localparam logic [7:0] FN_MULTI_REG = 8'h10;
  localparam logic [7:0] FN_REPORT = 8'h11;
  localparam logic [7:0] FN_OVR_OUT_RD = 8'h41;
  localparam logic [7:0] FN_OVR_IN_RD = 8'h42;
  localparam logic [7:0] FN_SCR_RD = 8'h43;
  localparam logic [7:0] FN_PROG_RD = 8'h44;
  localparam logic [7:0] FN_OVR_OUT_WR = 8'h45;
  localparam logic [7:0] FN_OVR_IN_WR = 8'h46;
  localparam logic [7:0] FN_SCR_WR = 8'h47;
  localparam logic [7:0] FN_PROG_WR = 8'h48;
  localparam logic [7:0] EXC_FLAG = 8'h80;
  localparam logic [7:0] SUB_FUNC = 8'h01;
  localparam logic [7:0] SUB_ADDR = 8'h02;
  localparam logic [7:0] SUB_DATA = 8'h03;
  localparam logic [7:0] SUB_FAIL = 8'h04;
  localparam logic [15:0] WORDS_MIN = 16'h0001;
  localparam logic [15:0] WORDS_MAX = 16'h007D;
  localparam logic [7:0] BYTES_MIN = 8'h02;
  localparam logic [7:0] BYTES_MAX = 8'hFA;
  localparam logic [16:0] PROG_MARGIN = 17'h0_0002;
  localparam logic [15:0] DIAG_ECHO = 16'h0000;
  localparam logic [15:0] DIAG_RESTART = 16'h0001;
  localparam logic [15:0] DIAG_RESET = 16'h0004;
  localparam logic [7:0] FORCE_ON = 8'hFF;
  localparam logic [16:0] SCR_RUN_END = 17'h0_0002;
  localparam logic [15:0] SCR_VEC_LO = 16'h005C;
  localparam logic [16:0] SCR_VEC_END = 17'h0_0080;
  localparam logic [8:0] FRAME_SHORT = 9'h004;
  localparam logic [8:0] FRAME_FIXED = 9'h008;
  localparam logic [8:0] FRAME_OVERHEAD = 9'h009;
  localparam logic [3:0] HDR_BYTES = 4'h7;
  localparam logic [1:0] GAP_CHARS = 2'h3;
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'hA001;
  localparam logic [2:0] EXC_LEN = 3'h3;
  localparam logic [2:0] NORM_LEN = 3'h6;
  typedef enum logic [5:0] {
    ST_RX = 6'b000001,
    ST_HOLD = 6'b000010,
    ST_JUDGE = 6'b000100,
    ST_STOP = 6'b001000,
    ST_WRITE = 6'b010000,
    ST_SEND = 6'b100000
  } state_t;
endpackage

// ===== src/rtu_slave_query_handler.sv
// Slave query handler: frames, checks and judges queries, writes program memory.
// Assumes receiver, transmitter and processor port all run on core_clk_in.
`timescale 1ns/1ps
module rtu_slave_query_handler #(
  parameter int BUF_WIDTH = 32,
  parameter int MEM_DEPTH = 128
) (
  input wire logic core_clk_in,
  input wire logic rstn_in,
  input wire logic [7:0] station_addr_in,
  input wire logic rx_valid_in,
  input wire logic [7:0] rx_data_in,
  input wire logic rx_error_in,
  input wire logic char_tick_in,
  input wire logic other_port_busy_in,
  input wire logic protect_in,
  input wire logic [15:0] prog_high_in,
  input wire logic [15:0] point_high_in,
  input wire logic [15:0] reg_high_in,
  input wire logic [15:0] scratch_high_in,
  input wire logic tx_ready_in,
  output logic tx_valid_out,
  output logic [7:0] tx_data_out,
  output logic cpu_stop_out,
  input wire logic cpu_stopped_in,
  input wire logic cpu_fail_in,
  output logic cpu_wr_valid_out,
  output logic [15:0] cpu_wr_addr_out,
  output logic [15:0] cpu_wr_data_out,
  input wire logic cpu_wr_ready_in,
  output logic svc_req_out,
  output logic [7:0] svc_fn_out
);
  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++)
    begin
      r = r[0] ? ((r >> 1) ^ rtu_query_pkg::CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  rtu_query_pkg::state_t st_q;
  logic [7:0] hdr_q [0:6];
  logic [15:0] mem_q [0:MEM_DEPTH-1];
  logic [8:0] ridx_q;
  logic [15:0] rxcrc_q;
  logic err_q;
  logic [1:0] gap_q;
  logic [7:0] hi_q;
  logic [1:0] prot_s_q;
  logic [1:0] busy_s_q;
  logic exc_q;
  logic [7:0] sub_q;
  logic [15:0] widx_q;
  logic [3:0] tidx_q;
  logic [15:0] txcrc_q;
  logic tx_valid_q;
  logic [7:0] tx_data_q;
  logic stop_q;
  logic svc_q;
  logic [7:0] svc_fn_q;
  logic [BUF_WIDTH-1:0] ent0_q;
  logic [BUF_WIDTH-1:0] ent1_q;
  logic vld0_q;
  logic vld1_q;

  // Query fields as received; start and count are high byte first.
  wire [7:0] fn = hdr_q[1];
  wire [15:0] f_a = {hdr_q[2], hdr_q[3]};
  wire [15:0] f_n = {hdr_q[4], hdr_q[5]};
  wire [7:0] f_bc = hdr_q[6];
  wire [16:0] f_sum = {1'b0, f_a} + {1'b0, f_n};
  wire bcast = (hdr_q[0] == rtu_query_pkg::BCAST_ADDR);

  // Frame length follows from the function code and, for data queries, the byte count.
  wire has_bc = (fn == rtu_query_pkg::FN_MULTI_PT) || (fn == rtu_query_pkg::FN_MULTI_REG)
    || (fn == rtu_query_pkg::FN_OVR_OUT_WR) || (fn == rtu_query_pkg::FN_OVR_IN_WR)
    || (fn == rtu_query_pkg::FN_SCR_WR) || (fn == rtu_query_pkg::FN_PROG_WR);
  wire no_body = (fn == rtu_query_pkg::FN_STATUS) || (fn == rtu_query_pkg::FN_REPORT);
  wire [8:0] bc_len = (f_bc == 8'h00) ? 9'h100 : {1'b0, f_bc};
  wire [8:0] need = has_bc ? (rtu_query_pkg::FRAME_OVERHEAD + bc_len)
    : (no_body ? rtu_query_pkg::FRAME_SHORT : rtu_query_pkg::FRAME_FIXED);
  wire [15:0] crc_rx_d = crc_byte(rxcrc_q, rx_data_in);
  wire rx_take = (st_q == rtu_query_pkg::ST_RX) && rx_valid_in;
  wire rx_last = rx_take && (ridx_q + 9'h001 == need);
  wire own_addr = (hdr_q[0] == station_addr_in) || bcast;
  wire rx_bad = err_q || rx_error_in || (crc_rx_d != 16'h0000) || !own_addr;
  wire gap_out = (st_q == rtu_query_pkg::ST_RX) && !rx_valid_in && char_tick_in
    && (ridx_q != 9'h000) && (gap_q == rtu_query_pkg::GAP_CHARS - 2'h1);
  wire [8:0] data_k = ridx_q - {5'h00, rtu_query_pkg::HDR_BYTES};

  // Judgement of a correctly received query, highest subcode priority first.
  wire fn_ok = ((fn >= rtu_query_pkg::FN_RD_OUT) && (fn <= rtu_query_pkg::FN_DIAG))
    || (fn == rtu_query_pkg::FN_MULTI_PT) || (fn == rtu_query_pkg::FN_MULTI_REG)
    || (fn == rtu_query_pkg::FN_REPORT)
    || ((fn >= rtu_query_pkg::FN_OVR_OUT_RD) && (fn <= rtu_query_pkg::FN_PROG_WR));
  wire pt_fn = (fn == rtu_query_pkg::FN_RD_OUT) || (fn == rtu_query_pkg::FN_RD_IN)
    || (fn == rtu_query_pkg::FN_MULTI_PT) || (fn == rtu_query_pkg::FN_OVR_OUT_RD)
    || (fn == rtu_query_pkg::FN_OVR_IN_RD) || (fn == rtu_query_pkg::FN_OVR_OUT_WR)
    || (fn == rtu_query_pkg::FN_OVR_IN_WR);
  wire reg_fn = (fn == rtu_query_pkg::FN_RD_HOLD) || (fn == rtu_query_pkg::FN_RD_INREG)
    || (fn == rtu_query_pkg::FN_MULTI_REG);
  wire prog_fn = (fn == rtu_query_pkg::FN_PROG_RD) || (fn == rtu_query_pkg::FN_PROG_WR);
  wire scr_wr_ok = (f_sum <= rtu_query_pkg::SCR_RUN_END)
    || ((f_a >= rtu_query_pkg::SCR_VEC_LO) && (f_sum <= rtu_query_pkg::SCR_VEC_END));
  wire diag_ok = (f_a == rtu_query_pkg::DIAG_ECHO) || (f_a == rtu_query_pkg::DIAG_RESTART)
    || (f_a == rtu_query_pkg::DIAG_RESET);
  wire addr_bad = (pt_fn && (f_sum > {1'b0, point_high_in}))
    || (reg_fn && (f_sum > {1'b0, reg_high_in}))
    || ((fn == rtu_query_pkg::FN_FORCE) && (f_a > point_high_in))
    || ((fn == rtu_query_pkg::FN_PRESET) && (f_a > reg_high_in))
    || ((fn == rtu_query_pkg::FN_DIAG) && !diag_ok)
    || ((fn == rtu_query_pkg::FN_SCR_RD)
      && (f_sum >= {1'b0, scratch_high_in} + rtu_query_pkg::PROG_MARGIN))
    || ((fn == rtu_query_pkg::FN_SCR_WR) && !scr_wr_ok)
    || (prog_fn && ((f_a > prog_high_in)
      || (f_sum >= {1'b0, prog_high_in} + rtu_query_pkg::PROG_MARGIN)));
  wire force_data_bad = ((fn == rtu_query_pkg::FN_FORCE)
    || ((fn == rtu_query_pkg::FN_DIAG) && (f_a == rtu_query_pkg::DIAG_RESTART)))
    && !(((hdr_q[4] == 8'h00) || (hdr_q[4] == rtu_query_pkg::FORCE_ON))
      && (hdr_q[5] == 8'h00));
  wire prog_data_bad = (fn == rtu_query_pkg::FN_PROG_WR)
    && ((f_n < rtu_query_pkg::WORDS_MIN) || (f_n > rtu_query_pkg::WORDS_MAX)
    || (f_bc < rtu_query_pkg::BYTES_MIN) || (f_bc > rtu_query_pkg::BYTES_MAX)
    || ({8'h00, f_bc} != {f_n[14:0], 1'b0}));
  wire prot_bad = (fn == rtu_query_pkg::FN_PROG_WR) && prot_s_q[1];
  wire [7:0] judge_sub = !fn_ok ? rtu_query_pkg::SUB_FUNC
    : addr_bad ? rtu_query_pkg::SUB_ADDR
    : (force_data_bad || prog_data_bad) ? rtu_query_pkg::SUB_DATA
    : prot_bad ? rtu_query_pkg::SUB_FAIL : 8'h00;

  // Program words drain through a two-entry buffer so a stalled processor loses nothing.
  wire buf_pop = vld0_q && cpu_wr_ready_in;
  wire buf_room = !vld1_q || buf_pop;
  wire in_write = (st_q == rtu_query_pkg::ST_WRITE);
  wire buf_push = in_write && (widx_q < f_n) && buf_room && !cpu_fail_in;
  wire [15:0] push_addr = f_a + widx_q;
  wire [BUF_WIDTH-1:0] push_ent = {push_addr, mem_q[widx_q[6:0]]};
  wire write_done = in_write && (widx_q == f_n) && !vld0_q;
  wire xfail = cpu_fail_in && ((st_q == rtu_query_pkg::ST_STOP) || in_write);

  // Reply bytes; the exception form replaces the code and carries the subcode.
  wire [3:0] tx_len = {1'b0, exc_q ? rtu_query_pkg::EXC_LEN : rtu_query_pkg::NORM_LEN};
  wire [7:0] msg_b = (tidx_q == 4'h1) ? (exc_q ? (fn | rtu_query_pkg::EXC_FLAG) : fn)
    : ((tidx_q == 4'h2) && exc_q) ? sub_q
    : hdr_q[tidx_q[2:0]];
  wire tx_slot = (st_q == rtu_query_pkg::ST_SEND) && (!tx_valid_q || tx_ready_in);
  wire tx_more = tidx_q < (tx_len + 4'h2);
  wire [7:0] tx_b = (tidx_q < tx_len) ? msg_b
    : (tidx_q == tx_len) ? txcrc_q[7:0] : txcrc_q[15:8];

  always_ff @(posedge core_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      prot_s_q <= 2'b00;
      busy_s_q <= 2'b00;
    end
    else
    begin
      prot_s_q <= {prot_s_q[0], protect_in};
      busy_s_q <= {busy_s_q[0], other_port_busy_in};
    end
  end

  // Receive framing: byte index, running check, error latch and silence counter.
  always_ff @(posedge core_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      ridx_q <= 9'h000;
      rxcrc_q <= rtu_query_pkg::CRC_INIT;
      err_q <= 1'b0;
      gap_q <= 2'h0;
    end
    else if (rx_take)
    begin
      ridx_q <= rx_last ? 9'h000 : ridx_q + 9'h001;
      rxcrc_q <= rx_last ? rtu_query_pkg::CRC_INIT : crc_rx_d;
      err_q <= !rx_last && (err_q || rx_error_in);
      gap_q <= 2'h0;
    end
    else if (gap_out)
    begin
      ridx_q <= 9'h000;
      rxcrc_q <= rtu_query_pkg::CRC_INIT;
      err_q <= 1'b0;
      gap_q <= 2'h0;
    end
    else if ((st_q == rtu_query_pkg::ST_RX) && char_tick_in && (ridx_q != 9'h000))
    begin
      gap_q <= gap_q + 2'h1;
    end
  end

  // Header bytes and staged program words; a dropped frame leaves them unused.
  always_ff @(posedge core_clk_in)
  begin
    if (rx_take && (ridx_q < {5'h00, rtu_query_pkg::HDR_BYTES}))
    begin
      hdr_q[ridx_q[2:0]] <= rx_data_in;
    end
    if (rx_take && (ridx_q >= {5'h00, rtu_query_pkg::HDR_BYTES})
      && (fn == rtu_query_pkg::FN_PROG_WR))
    begin
      if (!data_k[0])
      begin
        hi_q <= rx_data_in;
      end
      else
      begin
        mem_q[data_k[7:1]] <= {hi_q, rx_data_in};
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      st_q <= rtu_query_pkg::ST_RX;
      exc_q <= 1'b0;
      sub_q <= 8'h00;
      stop_q <= 1'b0;
      svc_q <= 1'b0;
      svc_fn_q <= 8'h00;
      widx_q <= 16'h0000;
      tidx_q <= 4'h0;
      txcrc_q <= rtu_query_pkg::CRC_INIT;
      tx_valid_q <= 1'b0;
      tx_data_q <= 8'h00;
    end
    else
    begin
      svc_q <= 1'b0;
      tidx_q <= (st_q == rtu_query_pkg::ST_SEND) ? tidx_q : 4'h0;
      txcrc_q <= (st_q == rtu_query_pkg::ST_SEND) ? txcrc_q : rtu_query_pkg::CRC_INIT;
      case (st_q)
        rtu_query_pkg::ST_RX:
        begin
          if (rx_last && !rx_bad)
          begin
            st_q <= rtu_query_pkg::ST_HOLD;
          end
        end
        rtu_query_pkg::ST_HOLD:
        begin
          if (!busy_s_q[1])
          begin
            st_q <= rtu_query_pkg::ST_JUDGE;
          end
        end
        rtu_query_pkg::ST_JUDGE:
        begin
          exc_q <= (judge_sub != 8'h00);
          sub_q <= judge_sub;
          widx_q <= 16'h0000;
          if (judge_sub != 8'h00)
          begin
            st_q <= bcast ? rtu_query_pkg::ST_RX : rtu_query_pkg::ST_SEND;
          end
          else if (fn == rtu_query_pkg::FN_PROG_WR)
          begin
            stop_q <= 1'b1;
            st_q <= rtu_query_pkg::ST_STOP;
          end
          else
          begin
            svc_q <= 1'b1;
            svc_fn_q <= fn;
            st_q <= rtu_query_pkg::ST_RX;
          end
        end
        rtu_query_pkg::ST_STOP:
        begin
          if (xfail || cpu_stopped_in)
          begin
            stop_q <= 1'b0;
            st_q <= !xfail ? rtu_query_pkg::ST_WRITE
              : bcast ? rtu_query_pkg::ST_RX : rtu_query_pkg::ST_SEND;
          end
        end
        rtu_query_pkg::ST_WRITE:
        begin
          widx_q <= buf_push ? widx_q + 16'h0001 : widx_q;
          if (xfail || write_done)
          begin
            st_q <= bcast ? rtu_query_pkg::ST_RX : rtu_query_pkg::ST_SEND;
          end
        end
        rtu_query_pkg::ST_SEND:
        begin
          if (tx_slot && tx_more)
          begin
            tx_valid_q <= 1'b1;
            tx_data_q <= tx_b;
            tidx_q <= tidx_q + 4'h1;
            txcrc_q <= (tidx_q < tx_len) ? crc_byte(txcrc_q, msg_b) : txcrc_q;
          end
          else if (tx_slot)
          begin
            tx_valid_q <= 1'b0;
            st_q <= rtu_query_pkg::ST_RX;
          end
        end
        default:
        begin
          st_q <= rtu_query_pkg::ST_RX;
        end
      endcase
      if (xfail)
      begin
        exc_q <= 1'b1;
        sub_q <= rtu_query_pkg::SUB_FAIL;
      end
    end
  end

  // A failed exchange flushes the buffer so stale words never reach the processor.
  always_ff @(posedge core_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      vld0_q <= 1'b0;
      vld1_q <= 1'b0;
      ent0_q <= '0;
      ent1_q <= '0;
    end
    else if (xfail)
    begin
      vld0_q <= 1'b0;
      vld1_q <= 1'b0;
    end
    else
    begin
      if (buf_pop)
      begin
        ent0_q <= vld1_q ? ent1_q : push_ent;
        vld0_q <= vld1_q || buf_push;
        vld1_q <= vld1_q && buf_push;
        ent1_q <= push_ent;
      end
      else if (buf_push && !vld0_q)
      begin
        ent0_q <= push_ent;
        vld0_q <= 1'b1;
      end
      else if (buf_push)
      begin
        ent1_q <= push_ent;
        vld1_q <= 1'b1;
      end
    end
  end

  assign tx_valid_out = tx_valid_q;
  assign tx_data_out = tx_data_q;
  assign cpu_stop_out = stop_q;
  assign cpu_wr_valid_out = vld0_q;
  assign cpu_wr_addr_out = ent0_q[31:16];
  assign cpu_wr_data_out = ent0_q[15:0];
  assign svc_req_out = svc_q;
  assign svc_fn_out = svc_fn_q;
endmodule // rtu_slave_query_handler

// ===== tb/rtu_query_asserts.sv
// Concurrent checks on the ports of the slave query handler.
// Assumes one clock domain and the asynchronous active-low reset.
`timescale 1ns/1ps
module rtu_query_asserts (
  input wire logic core_clk_in,
  input wire logic rstn_in,
  input wire logic [7:0] station_addr_in,
  input wire logic other_port_busy_in,
  input wire logic protect_in,
  input wire logic tx_ready_in,
  input wire logic tx_valid_out,
  input wire logic [7:0] tx_data_out,
  input wire logic cpu_stop_out,
  input wire logic cpu_stopped_in,
  input wire logic cpu_fail_in,
  input wire logic cpu_wr_valid_out,
  input wire logic [15:0] cpu_wr_addr_out,
  input wire logic [15:0] cpu_wr_data_out,
  input wire logic cpu_wr_ready_in
);
  logic stop_ok_q;
  logic have_q;
  logic [15:0] last_q;
  // An acknowledged stop is remembered until the reply starts, so each write can be traced to it.
  always_ff @(posedge core_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      stop_ok_q <= 1'b0;
      have_q <= 1'b0;
      last_q <= 16'h0000;
    end
    else
    begin
      stop_ok_q <= cpu_stopped_in || (stop_ok_q && !cpu_stop_out && !tx_valid_out);
      have_q <= !cpu_stop_out && (have_q || (cpu_wr_valid_out && cpu_wr_ready_in));
      if (cpu_wr_valid_out && cpu_wr_ready_in)
        last_q <= cpu_wr_addr_out;
    end
  end
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!rstn_in);
  property p_reply_head;
    $rose(tx_valid_out) |-> tx_data_out == station_addr_in && station_addr_in != 8'h00;
  endproperty
  a_reply_head: assert property (p_reply_head) else $error("reply head wrong");
  property p_tx_hold;
    tx_valid_out && !tx_ready_in |=> tx_valid_out && $stable(tx_data_out);
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("reply byte moved");
  property p_wr_hold;
    cpu_wr_valid_out && !cpu_wr_ready_in && !cpu_fail_in
      |=> cpu_wr_valid_out && $stable(cpu_wr_data_out);
  endproperty
  a_wr_hold: assert property (p_wr_hold) else $error("write word moved");
  property p_wr_ascend;
    cpu_wr_valid_out && cpu_wr_ready_in && have_q |-> cpu_wr_addr_out == last_q + 16'h0001;
  endproperty
  a_wr_ascend: assert property (p_wr_ascend) else $error("write address skipped");
  property p_wr_after_stop;
    cpu_wr_valid_out |-> stop_ok_q && !cpu_stop_out;
  endproperty
  a_wr_after_stop: assert property (p_wr_after_stop) else $error("write before stop");
  property p_stop_hold;
    cpu_stop_out && !cpu_stopped_in && !cpu_fail_in |=> cpu_stop_out;
  endproperty
  a_stop_hold: assert property (p_stop_hold) else $error("stop request dropped");
  property p_protect_blocks;
    protect_in [*4] |-> !$rose(cpu_stop_out);
  endproperty
  a_protect_blocks: assert property (p_protect_blocks) else $error("stop while protected");
  property p_busy_holds;
    other_port_busy_in [*8] |-> !$rose(tx_valid_out);
  endproperty
  a_busy_holds: assert property (p_busy_holds) else $error("reply while port busy");
  c_write: cover property (cpu_wr_valid_out && cpu_wr_ready_in);
  c_stop: cover property (cpu_stop_out && cpu_stopped_in);
  c_reply: cover property ($rose(tx_valid_out));
endmodule // rtu_query_asserts

// ===== tb/far_side_model.sv
// Transmitter and attached processor seen from the query handler.
// Assumes the bench's clock; transmit ready every second cycle, write ready and stop answer only one cycle in four.
`timescale 1ns/1ps
module far_side_model (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic fail_mode_in,
  input wire logic cpu_stop_in,
  output logic tx_ready_out,
  output logic cpu_stopped_out,
  output logic cpu_fail_out,
  output logic cpu_wr_ready_out
);
  logic [1:0] cnt_q;
  logic ack;
  assign ack = cpu_stop_in && cnt_q == 2'h3 && !cpu_stopped_out && !cpu_fail_out;
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      cnt_q <= 2'h0;
      tx_ready_out <= 1'b0;
      cpu_stopped_out <= 1'b0;
      cpu_fail_out <= 1'b0;
      cpu_wr_ready_out <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_q + 2'h1;
      tx_ready_out <= cnt_q[0];
      cpu_wr_ready_out <= cnt_q == 2'h2;
      cpu_stopped_out <= ack && !fail_mode_in;
      cpu_fail_out <= ack && fail_mode_in;
    end
  end
endmodule // far_side_model

// ===== tb/tb_rtu_slave_query_handler.sv
// Self-checking bench for the slave query handler.
// Assumes the checker and the far-side model are compiled first.
`timescale 1ns/1ps
module tb_rtu_slave_query_handler;
  typedef struct packed {logic [7:0] ad; logic [7:0] fn; logic [31:0] arg; logic [7:0] sub;} row_t;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic rx_valid = 1'b0;
  logic [7:0] rx_data = 8'h00;
  logic rx_error = 1'b0;
  logic tick = 1'b0;
  logic busy = 1'b0;
  logic protect = 1'b0;
  logic fail_mode = 1'b0;
  logic [3:0] tcnt = 4'h0;
  logic tx_ready, tx_valid, stop, stopped, fail, wr_valid, wr_ready, svc;
  logic [7:0] tx_data;
  logic [7:0] svc_fn, last_fn;
  logic [15:0] wr_addr, wr_data;
  logic [7:0] txq[$];
  logic [7:0] none[$];
  logic [7:0] q9[$];
  logic [15:0] wq[$];
  int n_fail = 0;
  int checked = 0;
  int nsvc = 0;
  int n0;
  row_t r;
  row_t rows[15] = '{'{8'h11, 8'h09, 32'h0000_0001, 8'h01}, '{8'h11, 8'h40, 32'h0000_0001, 8'h01},
    '{8'h11, 8'h49, 32'h0000_0001, 8'h01}, '{8'h11, 8'h03, 32'h0010_0010, 8'h00},
    '{8'h11, 8'h03, 32'h0010_0011, 8'h02}, '{8'h11, 8'h05, 32'h0041_FF00, 8'h02},
    '{8'h11, 8'h05, 32'h0010_5500, 8'h03}, '{8'h11, 8'h08, 32'h0002_0000, 8'h02},
    '{8'h11, 8'h08, 32'h0001_FF01, 8'h03}, '{8'h11, 8'h08, 32'h0001_FF00, 8'h00},
    '{8'h11, 8'h44, 32'h00FF_0003, 8'h02}, '{8'h11, 8'h43, 32'h007F_0002, 8'h02},
    '{8'h00, 8'h09, 32'h0000_0001, 8'hFF}, '{8'h22, 8'h09, 32'h0000_0001, 8'hFF},
    '{8'h11, 8'h43, 32'h0006_0009, 8'h00}};
  rtu_slave_query_handler rtu_slave_query_handler_inst (
    .core_clk_in(clk), .rstn_in(rstn), .station_addr_in(8'h11), .rx_valid_in(rx_valid),
    .rx_data_in(rx_data), .rx_error_in(rx_error), .char_tick_in(tick),
    .other_port_busy_in(busy), .protect_in(protect), .prog_high_in(16'h0100),
    .point_high_in(16'h0040), .reg_high_in(16'h0020), .scratch_high_in(16'h007F),
    .tx_ready_in(tx_ready), .tx_valid_out(tx_valid), .tx_data_out(tx_data),
    .cpu_stop_out(stop), .cpu_stopped_in(stopped), .cpu_fail_in(fail),
    .cpu_wr_valid_out(wr_valid), .cpu_wr_addr_out(wr_addr), .cpu_wr_data_out(wr_data),
    .cpu_wr_ready_in(wr_ready), .svc_req_out(svc), .svc_fn_out(svc_fn));
  far_side_model far_side_model_inst (
    .clk_in(clk), .rstn_in(rstn), .fail_mode_in(fail_mode), .cpu_stop_in(stop),
    .tx_ready_out(tx_ready), .cpu_stopped_out(stopped), .cpu_fail_out(fail),
    .cpu_wr_ready_out(wr_ready));
  always #50 clk = ~clk;
  task automatic step();
    @(posedge clk);
    #1;
  endtask
  always
  begin
    step();
    tcnt++;
    tick = tcnt == 4'h0;
  end
  always @(posedge clk)
  begin
    if (tx_valid && tx_ready)
      txq.push_back(tx_data);
    if (wr_valid && wr_ready)
      wq = {wq, wr_addr, wr_data};
    if (svc)
      last_fn = svc_fn;
    nsvc += int'(svc);
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [15:0] crc(input logic [7:0] q[$]);
    logic [15:0] c;
    c = 16'hFFFF;
    foreach (q[i])
    begin
      c ^= {8'h00, q[i]};
      repeat (8) c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
    end
    return c;
  endfunction
  // Mode 1 spoils the check field, 2 flags a line error, 3 sends no check field at all.
  task automatic send(input logic [7:0] q[$], input int mode);
    logic [15:0] c;
    c = crc(q);
    if (mode != 3)
      q = {q, c[7:0] ^ {7'h00, mode == 1}, c[15:8]};
    foreach (q[i])
    begin
      rx_valid = 1'b1;
      rx_data = q[i];
      rx_error = mode == 2 && i == q.size() - 1;
      step();
      rx_valid = 1'b0;
      rx_error = 1'b0;
      step();
    end
  endtask
  task automatic write72(input logic [7:0] ad, input logic [15:0] st, n, input logic [7:0] bc);
    logic [7:0] q[$];
    q = {ad, rtu_query_pkg::FN_PROG_WR, st[15:8], st[7:0], n[15:8], n[7:0], bc};
    for (int j = 0; j < bc; j++)
      q.push_back(j[0] ? 8'(j / 2) : 8'hA0);
    send(q, 0);
  endtask
  task automatic expect_reply(input logic [7:0] e[$]);
    logic [15:0] c;
    int k;
    c = crc(e);
    if (e.size() > 0)
      e = {e, c[7:0], c[15:8]};
    k = 0;
    while (k < 60 || (k < 2000 && txq.size() < e.size()))
    begin
      step();
      k++;
    end
    check(16'(txq.size()), 16'(e.size()));
    foreach (e[i])
      if (i < txq.size())
        check({8'h00, txq[i]}, {8'h00, e[i]});
    txq.delete();
  endtask
  task automatic exc(input logic [7:0] fn, input logic [7:0] sub);
    expect_reply({8'h11, fn | rtu_query_pkg::EXC_FLAG, sub});
  endtask
  task automatic check_writes(input logic [15:0] st, input int n);
    check(16'(wq.size()), 16'(2 * n));
    for (int k = 0; k < n && 2 * k + 1 < wq.size(); k++)
    begin
      check(wq[2 * k], st + 16'(k));
      check(wq[2 * k + 1], 16'hA000 + 16'(k));
    end
    wq.delete();
  endtask
  task automatic conclude();
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    #3_000_000;
    n_fail++;
    conclude();
  end
  initial
  begin
    q9 = {8'h11, 8'h09, 8'h00, 8'h00, 8'h00, 8'h01};
    repeat (2) step();
    check({12'h000, tx_valid, stop, wr_valid, svc}, 16'h0000);
    rstn = 1'b1;
    repeat (3) step();
    foreach (rows[i])
    begin
      r = rows[i];
      n0 = nsvc;
      send({r.ad, r.fn, r.arg[31:24], r.arg[23:16], r.arg[15:8], r.arg[7:0]}, 0);
      if (r.sub == 8'h00 || r.sub == 8'hFF)
        expect_reply(none);
      else
        exc(r.fn, r.sub);
      check(16'(nsvc - n0), {15'h0000, r.sub == 8'h00});
      if (r.sub == 8'h00)
        check({8'h00, last_fn}, {8'h00, r.fn});
    end
    $display("test done: query table");
    write72(8'h11, 16'h00FF, 16'h0002, 8'h04);
    expect_reply({8'h11, rtu_query_pkg::FN_PROG_WR, 8'h00, 8'hFF, 8'h00, 8'h02});
    check_writes(16'h00FF, 2);
    write72(8'h11, 16'h0000, 16'h007D, 8'hFA);
    expect_reply({8'h11, rtu_query_pkg::FN_PROG_WR, 8'h00, 8'h00, 8'h00, 8'h7D});
    check_writes(16'h0000, 125);
    $display("test done: program write");
    write72(8'h11, 16'h0100, 16'h0002, 8'h04);
    exc(rtu_query_pkg::FN_PROG_WR, rtu_query_pkg::SUB_ADDR);
    write72(8'h11, 16'h0000, 16'h0000, 8'h02);
    exc(rtu_query_pkg::FN_PROG_WR, rtu_query_pkg::SUB_DATA);
    write72(8'h11, 16'h0000, 16'h007E, 8'hFC);
    exc(rtu_query_pkg::FN_PROG_WR, rtu_query_pkg::SUB_DATA);
    write72(8'h11, 16'h0000, 16'h0002, 8'h02);
    exc(rtu_query_pkg::FN_PROG_WR, rtu_query_pkg::SUB_DATA);
    protect = 1'b1;
    repeat (5) step();
    write72(8'h11, 16'h0010, 16'h0001, 8'h02);
    exc(rtu_query_pkg::FN_PROG_WR, rtu_query_pkg::SUB_FAIL);
    protect = 1'b0;
    fail_mode = 1'b1;
    write72(8'h11, 16'h0010, 16'h0001, 8'h02);
    exc(rtu_query_pkg::FN_PROG_WR, rtu_query_pkg::SUB_FAIL);
    fail_mode = 1'b0;
    check_writes(16'h0010, 0);
    write72(8'h00, 16'h0020, 16'h0002, 8'h04);
    expect_reply(none);
    check_writes(16'h0020, 2);
    $display("test done: refusals");
    send(q9, 1);
    expect_reply(none);
    send(q9, 2);
    expect_reply(none);
    send(q9[0:2], 3);
    repeat (60) step();
    send(q9, 0);
    exc(8'h09, rtu_query_pkg::SUB_FUNC);
    busy = 1'b1;
    send(q9, 0);
    repeat (100) step();
    check(16'(txq.size()), 16'h0000);
    busy = 1'b0;
    exc(8'h09, rtu_query_pkg::SUB_FUNC);
    $display("test done: line faults");
    conclude();
  end
endmodule // tb_rtu_slave_query_handler
bind rtu_slave_query_handler rtu_query_asserts chk_inst (
  .core_clk_in(core_clk_in), .rstn_in(rstn_in), .station_addr_in(station_addr_in),
  .other_port_busy_in(other_port_busy_in), .protect_in(protect_in), .tx_ready_in(tx_ready_in),
  .tx_valid_out(tx_valid_out), .tx_data_out(tx_data_out), .cpu_stop_out(cpu_stop_out),
  .cpu_stopped_in(cpu_stopped_in), .cpu_wr_valid_out(cpu_wr_valid_out),
  .cpu_wr_addr_out(cpu_wr_addr_out), .cpu_wr_data_out(cpu_wr_data_out),
  .cpu_wr_ready_in(cpu_wr_ready_in), .cpu_fail_in(cpu_fail_in));
